// ### bbd_core.sv
// branch, bit manipulation, control and long jump execution core
// What this block does
// - four one-byte branches on carry/zero set/clear, two cycles, flags kept.
// - short branch uses 5-bit signed displacement, reach -15 to +16.
// - bit test branches on bit 0 or 1, three bytes, five cycles.
// - bit test copies tested bit into carry, zero untouched.
// - bit set/clear on any data byte, 3-bit bit field, four cycles.
// - with watchdog option selected, stop opcode performs wait instead.
// - long jump and call reach 12-bit address, four cycles, flags kept.
// - control opcodes take two cycles; only interrupt return changes flags.
// - low nibble decode of branches, call, bit test; 0x04 is no-op.
// - low nibble 0111 selects load, compare, add, increment by high nibble.
// - short branch opcode holds condition, direction and span bits.
// - extended target joins four opcode bits with the following byte.
`timescale 1ns/100ps
module bbd_core
	import bbd_pkg::*;
#(
	parameter int STACK_LEVELS = STACK_DEPTH
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	output logic [11:0]      pm_addr,
	output logic             pm_rd,
	input  wire logic [7:0]  pm_data,
	output logic [7:0]       dm_addr,
	output logic             dm_rd,
	output logic             dm_wr,
	output logic [7:0]       dm_wdata,
	input  wire logic [7:0]  dm_rdata,
	input  wire logic        watchdog_sel,
	input  wire logic        irq_pin,
	output logic [7:0]       acc,
	output logic             flag_z,
	output logic             flag_c,
	output logic [11:0]      pc,
	output logic             halt_stop,
	output logic             halt_wait
);
	typedef struct packed {
		bbd_state_e  st;
		logic        ph;
		logic        wd_s1;
		logic        wd_s2;
		logic        irq_s1;
		logic        irq_s2;
		logic [11:0] pc;
		logic [11:0] ia;
		logic [7:0]  op;
		logic [7:0]  b2;
		logic [7:0]  b3;
		logic [7:0]  db;
		logic [7:0]  ptr;
		logic [7:0]  acc;
		logic        z;
		logic        c;
		logic        iz;
		logic        ic;
		logic        in_irq;
		logic        hstop;
		logic        hwait;
		logic [11:0] pm_addr;
		logic        pm_rd;
		logic [7:0]  dm_addr;
		logic        dm_rd;
		logic        dm_wr;
		logic [7:0]  dm_wdata;
		logic [2:0]  cyc;
	} bbd_core_s;

	localparam bbd_core_s RST_S = '{st: ST_EXEC, op: OP_NOP, cyc: 3'h1, default: '0};

	bbd_core_s   s_q;
	bbd_core_s   s_d;
	logic [1:0]  rsync_q;
	logic        rst_q;
	bbd_class_e  cls;
	bbd_class_e  fcls;
	logic [2:0]  bitn;
	logic [7:0]  mask;
	logic        tbit;
	logic        cond_ok;
	logic [2:0]  cyc_exp;
	logic        fin;
	logic        push;
	logic        pop;
	logic [11:0] push_data;
	logic [11:0] top;
	logic [8:0]  alu9;
	logic [7:0]  src;

	function automatic bbd_class_e cls_of(input logic [7:0] op);
		bbd_class_e r;
		r = CL_NOP;
		case (op[3:0])
			LN_BRANCH_IF_NOT_ZERO, LN_BRANCH_IF_NO_CARRY, LN_JRZ, LN_JRC: r = (op == OP_NOP) ? CL_NOP : CL_REL;
			LN_CALL, LN_JP: r = CL_EXT;
			LN_BTB: r = CL_BTB;
			LN_BIT: r = CL_BIT;
			LN_ALU: r = (op[7:4] <= HN_INC_IND) ? CL_ALU : CL_NOP;
			default: begin
				// even low nibbles 8, A, C, E carry the odd short displacements
				if (!op[0]) begin
					r = CL_REL;
				end else if (op == OP_RET || op == OP_INTERRUPT_EXIT || op == OP_STOP || op == OP_WAIT) begin
					r = CL_CTL;
				end else begin
					r = CL_NOP;
				end
			end
		endcase
		return r;
	endfunction

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rsync_q <= 2'h0;
		end else begin
			rsync_q <= {rsync_q[0], 1'b1};
		end
	end
	assign rst_q = rsync_q[1];

	// bit number sits reversed in opcode bits 7..5
	assign cls = cls_of(s_q.op);
	assign fcls = cls_of(pm_data);
	assign bitn = {s_q.op[5], s_q.op[6], s_q.op[7]};
	assign mask = 8'(8'h01 << bitn);
	assign tbit = s_q.db[bitn];
	assign src = s_q.op[4] ? s_q.b2 : s_q.db;

	always_comb begin
		case (s_q.op[2:1])
			2'h0: cond_ok = !s_q.z;
			2'h1: cond_ok = !s_q.c;
			2'h2: cond_ok = s_q.z;
			default: cond_ok = s_q.c;
		endcase
		case (cls)
			CL_BTB: cyc_exp = CYC_BTB;
			CL_BIT, CL_EXT, CL_ALU: cyc_exp = CYC_FOUR;
			default: cyc_exp = CYC_SHORT;
		endcase
	end

	always_comb begin
		s_d = s_q;
		fin = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		push_data = s_q.pc;
		alu9 = 9'h000;
		s_d.wd_s1 = watchdog_sel;
		s_d.wd_s2 = s_q.wd_s1;
		s_d.irq_s1 = irq_pin;
		s_d.irq_s2 = s_q.irq_s1;
		s_d.ph = !s_q.ph;
		if (s_q.ph) begin
			s_d.pm_rd = 1'b0;
			s_d.dm_rd = 1'b0;
			s_d.dm_wr = 1'b0;
			s_d.cyc = s_q.cyc + 3'h1;
			case (s_q.st)
				ST_FETCH: begin
					s_d.op = pm_data;
					s_d.ia = s_q.pc;
					s_d.pc = s_q.pc + 12'h001;
					case (fcls)
						CL_BTB, CL_BIT, CL_EXT: s_d.st = ST_BYTE2;
						CL_ALU: s_d.st = pm_data[4] ? ST_BYTE2 : ST_PTR;
						default: s_d.st = ST_EXEC;
					endcase
				end
				ST_BYTE2: begin
					s_d.b2 = pm_data;
					s_d.pc = s_q.pc + 12'h001;
					case (cls)
						CL_BTB: s_d.st = ST_BYTE3;
						CL_BIT: s_d.st = ST_DRD;
						default: s_d.st = ST_IDLE;
					endcase
				end
				ST_BYTE3: begin
					s_d.b3 = pm_data;
					s_d.pc = s_q.pc + 12'h001;
					s_d.st = ST_DRD;
				end
				ST_PTR: begin
					s_d.ptr = dm_rdata;
					s_d.st = ST_DRD;
				end
				ST_DRD: begin
					s_d.db = dm_rdata;
					s_d.st = ST_EXEC;
					if (cls == CL_BIT) begin
						// read-modify-write touches only the addressed bit
						s_d.dm_wdata = s_q.op[4] ? (dm_rdata | mask) : (dm_rdata & ~mask);
						s_d.st = ST_DWR;
					end else if (cls == CL_ALU && s_q.op[7:4] == HN_INC_IND) begin
						s_d.dm_wdata = dm_rdata + 8'h01;
						s_d.st = ST_DWR;
					end
				end
				ST_IDLE: s_d.st = ST_EXEC;
				ST_DWR: begin
					if (cls == CL_ALU) begin
						s_d.z = (s_q.dm_wdata == 8'h00);
					end
					fin = 1'b1;
				end
				ST_EXEC: begin
					fin = 1'b1;
					case (cls)
						CL_REL: begin
							if (cond_ok) begin
								s_d.pc = s_q.pc + {{7{s_q.op[7]}}, s_q.op[7:3]};
							end
						end
						CL_BTB: begin
							s_d.c = tbit;
							if (tbit == s_q.op[4]) begin
								s_d.pc = s_q.pc + {{4{s_q.b3[7]}}, s_q.b3} - 12'h001;
							end
						end
						CL_EXT: begin
							if (s_q.op[3:0] == LN_CALL) begin
								push = 1'b1;
							end
							s_d.pc = {s_q.op[7:4], s_q.b2};
						end
						CL_CTL: begin
							if (s_q.op == OP_RET || s_q.op == OP_INTERRUPT_EXIT) begin
								pop = 1'b1;
								s_d.pc = top;
							end
							if (s_q.op == OP_INTERRUPT_EXIT) begin
								s_d.z = s_q.iz;
								s_d.c = s_q.ic;
								s_d.in_irq = 1'b0;
							end
							if (s_q.op == OP_STOP || s_q.op == OP_WAIT) begin
								fin = 1'b0;
								s_d.st = ST_HALT;
								s_d.hstop = (s_q.op == OP_STOP) && !s_q.wd_s2;
								s_d.hwait = (s_q.op == OP_WAIT) || s_q.wd_s2;
							end
						end
						CL_ALU: begin
							case (s_q.op[7:4])
								HN_LD_IND, HN_LDI: begin
									s_d.acc = src;
									s_d.z = (src == 8'h00);
								end
								HN_CP_IND, HN_CPI: begin
									alu9 = {1'b0, s_q.acc} - {1'b0, src};
									s_d.z = (alu9[7:0] == 8'h00);
									s_d.c = alu9[8];
								end
								HN_ADD_IND, HN_SUM_IMMEDIATE: begin
									alu9 = {1'b0, s_q.acc} + {1'b0, src};
									s_d.acc = alu9[7:0];
									s_d.z = (alu9[7:0] == 8'h00);
									s_d.c = alu9[8];
								end
								default: s_d.acc = s_q.acc;
							endcase
						end
						default: s_d.acc = s_q.acc;
					endcase
				end
				ST_HALT: begin
					if (s_q.irq_s2) begin
						s_d.hstop = 1'b0;
						s_d.hwait = 1'b0;
						fin = 1'b1;
					end
				end
				default: s_d.st = ST_EXEC;
			endcase
			if (fin) begin
				s_d.st = ST_FETCH;
				s_d.cyc = 3'h0;
				// interrupt taken only at a boundary with no stack traffic
				if (s_q.irq_s2 && !s_q.in_irq && !push && !pop) begin
					push = 1'b1;
					push_data = s_d.pc;
					s_d.pc = IRQ_VECTOR;
					s_d.iz = s_d.z;
					s_d.ic = s_d.c;
					s_d.in_irq = 1'b1;
				end
			end
			case (s_d.st)
				ST_FETCH, ST_BYTE2, ST_BYTE3: begin
					s_d.pm_addr = s_d.pc;
					s_d.pm_rd = 1'b1;
				end
				ST_PTR: begin
					s_d.dm_addr = PTR_X_ADDR;
					s_d.dm_rd = 1'b1;
				end
				ST_DRD: begin
					s_d.dm_addr = (cls == CL_ALU) ? s_d.ptr : s_d.b2;
					s_d.dm_rd = 1'b1;
				end
				ST_DWR: s_d.dm_wr = 1'b1;
				default: s_d.dm_wr = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_q) begin
		if (!rst_q) begin
			s_q <= RST_S;
		end else begin
			s_q <= s_d;
		end
	end

	bbd_ret_stack #(
		.DEPTH (STACK_LEVELS),
		.WIDTH (PC_W)
	) u_stack (
		.clock     (clock),
		.rst_q     (rst_q),
		.push      (push),
		.pop       (pop),
		.push_data (push_data),
		.top       (top)
	);

	assign pm_addr = s_q.pm_addr;
	assign pm_rd = s_q.pm_rd;
	assign dm_addr = s_q.dm_addr;
	assign dm_rd = s_q.dm_rd;
	assign dm_wr = s_q.dm_wr;
	assign dm_wdata = s_q.dm_wdata;
	assign acc = s_q.acc;
	assign flag_z = s_q.z;
	assign flag_c = s_q.c;
	assign pc = s_q.pc;
	assign halt_stop = s_q.hstop;
	assign halt_wait = s_q.hwait;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_q);

	rel_flags_a: assert property (
		s_q.ph && s_q.st == ST_EXEC && cls == CL_REL |=> s_q.z == $past(s_q.z) && s_q.c == $past(s_q.c))
		else $error("short branch changed a flag");
	rel_target_a: assert property (
		s_q.ph && s_q.st == ST_EXEC && cls == CL_REL && cond_ok && !s_q.irq_s2
		|=> s_q.pc == $past(s_q.ia) + 12'h001 + {{7{$past(s_q.op[7])}}, $past(s_q.op[7:3])})
		else $error("short branch target wrong");
	btb_carry_a: assert property (
		s_q.ph && s_q.st == ST_EXEC && cls == CL_BTB |=> s_q.c == $past(tbit) && $stable(s_q.z))
		else $error("bit test carry wrong");
	inst_cycles_a: assert property (
		s_q.ph && fin && (s_q.st == ST_EXEC || s_q.st == ST_DWR) |-> s_q.cyc + 3'h1 == cyc_exp)
		else $error("instruction cycle count wrong");
	stop_wd_a: assert property (
		s_q.ph && s_q.st == ST_EXEC && s_q.op == OP_STOP && s_q.wd_s2
		|=> s_q.hwait && !s_q.hstop && s_q.st == ST_HALT)
		else $error("stop not turned into wait");
	bit_write_a: assert property (
		s_q.dm_wr && cls == CL_BIT
		|-> ((s_q.dm_wdata ^ s_q.db) & ~mask) == 8'h00 && s_q.dm_wdata[bitn] == s_q.op[4])
		else $error("bit set or clear wrote wrong byte");
	ext_target_a: assert property (
		s_q.ph && s_q.st == ST_EXEC && cls == CL_EXT && !s_q.irq_s2
		|=> s_q.pc == {$past(s_q.op[7:4]), $past(s_q.b2)} && $stable(s_q.z) && $stable(s_q.c))
		else $error("long jump target wrong");
	nop_keep_a: assert property (
		s_q.ph && s_q.st == ST_EXEC && cls == CL_NOP && !s_q.irq_s2
		|=> $stable(s_q.pc) && $stable(s_q.acc) && $stable(s_q.z) && $stable(s_q.c))
		else $error("no-op changed state");
	add_sum_a: assert property (
		s_q.ph && s_q.st == ST_EXEC && cls == CL_ALU && s_q.op[7:4] == HN_SUM_IMMEDIATE
		|=> s_q.acc == 8'($past(s_q.acc) + $past(s_q.b2)))
		else $error("add immediate result wrong");
	ret_flags_a: assert property (
		s_q.ph && s_q.st == ST_EXEC && s_q.op == OP_RET |=> $stable(s_q.z) && $stable(s_q.c))
		else $error("return changed a flag");
endmodule

// ### bbd_mem_model.sv
// program and data space memory model
`timescale 1ns/100ps
module bbd_mem_model (
	input  wire logic        clock,
	input  wire logic [11:0] pm_addr,
	input  wire logic        pm_rd,
	output logic      [7:0]  pm_data,
	input  wire logic [7:0]  dm_addr,
	input  wire logic        dm_rd,
	input  wire logic        dm_wr,
	input  wire logic [7:0]  dm_wdata,
	output logic      [7:0]  dm_rdata
);
	logic [7:0] pmem [4096];
	logic [7:0] dmem [256];
	initial begin
		pm_data = 8'h00;
		dm_rdata = 8'h00;
	end
	// answer one clock after the request, inverted while idle
	always @(posedge clock) begin
		pm_data <= pm_rd ? pmem[pm_addr] : ~pm_data;
		dm_rdata <= dm_rd ? dmem[dm_addr] : ~dm_rdata;
		// plain storage only, no port or split-access bytes
		if (dm_wr) dmem[dm_addr] <= dm_wdata;
	end
endmodule

// ### bbd_pkg.sv
// constants and types for the branch, bit and control decoder core
package bbd_pkg;

	localparam int          PC_W        = 12;
	localparam logic [7:0]  OP_NOP      = 8'h04;
	localparam logic [7:0]  OP_RET      = 8'hCD;
	localparam logic [7:0]  OP_INTERRUPT_EXIT     = 8'h4D;
	localparam logic [7:0]  OP_STOP     = 8'h6D;
	localparam logic [7:0]  OP_WAIT     = 8'hED;
	localparam logic [7:0]  PTR_X_ADDR  = 8'h80;
	localparam logic [11:0] IRQ_VECTOR  = 12'hFF0;

	localparam logic [3:0]  LN_BRANCH_IF_NOT_ZERO     = 4'h0;
	localparam logic [3:0]  LN_CALL     = 4'h1;
	localparam logic [3:0]  LN_BRANCH_IF_NO_CARRY     = 4'h2;
	localparam logic [3:0]  LN_BTB      = 4'h3;
	localparam logic [3:0]  LN_JRZ      = 4'h4;
	localparam logic [3:0]  LN_JRC      = 4'h6;
	localparam logic [3:0]  LN_ALU      = 4'h7;
	localparam logic [3:0]  LN_JP       = 4'h9;
	localparam logic [3:0]  LN_BIT      = 4'hB;

	localparam logic [3:0]  HN_LD_IND   = 4'h0;
	localparam logic [3:0]  HN_LDI      = 4'h1;
	localparam logic [3:0]  HN_CP_IND   = 4'h2;
	localparam logic [3:0]  HN_CPI      = 4'h3;
	localparam logic [3:0]  HN_ADD_IND  = 4'h4;
	localparam logic [3:0]  HN_SUM_IMMEDIATE     = 4'h5;
	localparam logic [3:0]  HN_INC_IND  = 4'h6;

	localparam logic [2:0]  CYC_SHORT   = 3'h2;
	localparam logic [2:0]  CYC_FOUR    = 3'h4;
	localparam logic [2:0]  CYC_BTB     = 3'h5;

	localparam int          STACK_DEPTH = 8;

	typedef enum logic [8:0] {
		ST_FETCH = 9'h001,
		ST_BYTE2 = 9'h002,
		ST_BYTE3 = 9'h004,
		ST_PTR   = 9'h008,
		ST_DRD   = 9'h010,
		ST_IDLE  = 9'h020,
		ST_DWR   = 9'h040,
		ST_EXEC  = 9'h080,
		ST_HALT  = 9'h100
	} bbd_state_e;

	typedef enum logic [2:0] {
		CL_NOP = 3'h0,
		CL_REL = 3'h1,
		CL_BTB = 3'h2,
		CL_BIT = 3'h3,
		CL_EXT = 3'h4,
		CL_CTL = 3'h5,
		CL_ALU = 3'h6
	} bbd_class_e;

endpackage

// ### bbd_ret_stack.sv
// return address stack with registered top of stack
`timescale 1ns/100ps
module bbd_ret_stack #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 12
) (
	input  wire logic             clock,
	input  wire logic             rst_q,
	input  wire logic             push,
	input  wire logic             pop,
	input  wire logic [WIDTH-1:0] push_data,
	output logic      [WIDTH-1:0] top
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("stack depth must be a power of two, at least 2");
		end
	endgenerate

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               sp;
		logic [WIDTH-1:0]            top;
	} bbd_stack_s;

	bbd_stack_s s_q;
	bbd_stack_s s_d;

	// pointer wraps: overflow overwrites the oldest entry
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.sp] = push_data;
			s_d.sp = s_q.sp + AW'(1);
			s_d.top = push_data;
		end else if (pop) begin
			s_d.sp = s_q.sp - AW'(1);
			s_d.top = s_q.mem[s_q.sp - AW'(2)];
		end
	end

	always_ff @(posedge clock or negedge rst_q) begin
		if (!rst_q) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign top = s_q.top;
endmodule

// ### test_branch_bit_control_decoder.sv
// self-checking bench for the branch, bit and control decoder core
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("unexpected %0t got %0h exp %0h", $time, (g), (e)); end end
module test_branch_bit_control_decoder;
	import bbd_pkg::*;
	logic        clock, rst_n, watchdog_sel, irq_pin, pm_rd, dm_rd, dm_wr, flag_z, flag_c, halt_stop, halt_wait, ph;
	logic [11:0] pm_addr, pc;
	logic [7:0]  pm_data, dm_addr, dm_wdata, dm_rdata, acc;
	logic [11:0] fa [64];
	int          ft [64];
	int          n_errors, check_count, nf, cyc;
	logic [7:0]  ctl [5] = '{OP_NOP, 8'h05, 8'h45, OP_STOP, OP_WAIT};

	bbd_core u_dut (.clock(clock), .rst_n(rst_n), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data),
		.dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata),
		.watchdog_sel(watchdog_sel), .irq_pin(irq_pin), .acc(acc), .flag_z(flag_z), .flag_c(flag_c),
		.pc(pc), .halt_stop(halt_stop), .halt_wait(halt_wait));
	bbd_mem_model u_mem (.clock(clock), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data), .dm_addr(dm_addr),
		.dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// log address and clock of every opcode or operand fetch
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (!rst_n || !pm_rd) ph <= 1'b0;
		else begin
			ph <= !ph;
			if (!ph && nf < 64) begin
				fa[nf] <= pm_addr;
				ft[nf] <= cyc;
				nf <= nf + 1;
			end
		end
		if (!rst_n) nf <= 0;
	end

	function automatic logic [7:0] btop(input logic [2:0] bb, input logic ss);
		return {bb[0], bb[1], bb[2], ss, LN_BTB};
	endfunction

	task automatic put(input logic [11:0] ad, input logic [7:0] x, input logic [7:0] y, input logic [7:0] w);
		u_mem.pmem[ad] = x;
		u_mem.pmem[ad + 12'h1] = y;
		u_mem.pmem[ad + 12'h2] = w;
	endtask

	task automatic wait_halt(input logic want);
		int n;
		n = 0;
		while ((halt_wait | halt_stop) !== want && n < 600) begin
			@(negedge clock);
			n++;
		end
		`CHK(halt_wait | halt_stop, want)
	endtask

	task automatic run_one(input int i);
		logic [7:0]  op, b1, b2, v, rrp, d, zv;
		logic [11:0] base, a, tgt;
		logic [3:0]  n4;
		logic [2:0]  b, bp;
		logic        s, z, c, tk, call;
		int          nb, cy, k;
		for (k = 0; k < 4096; k++) u_mem.pmem[k] = OP_WAIT;
		for (k = 0; k < 256; k++) u_mem.dmem[k] = 8'($urandom);
		base = 12'h100 + 12'($urandom % 1280);
		a = base + 12'h100;
		v = ($urandom % 3 == 0) ? 8'h00 : 8'($urandom);
		rrp = 8'($urandom);
		bp = 3'($urandom);
		b = 3'($urandom);
		s = 1'($urandom);
		z = (v == 8'h00);
		c = u_mem.dmem[rrp][bp];
		zv = z ? 8'h5A : 8'h00;
		b1 = OP_WAIT;
		b2 = OP_WAIT;
		d = 8'h00;
		nb = 1;
		cy = 2;
		call = 1'b0;
		tgt = 12'h800 + 12'($urandom % 1792);
		n4 = (i < 8) ? 4'h8 : (i < 16) ? 4'h7 : 4'($urandom % 15);
		case (i % 8)
			0, 1, 2, 3: begin
				op = {n4, 1'(i / 8), 3'(2 * (i % 8))};
				tk = (op[2:1] == 2'd0) ? !z : (op[2:1] == 2'd1) ? !c : (op[2:1] == 2'd2) ? z : c;
				tgt = a + 12'h1 + (tk ? {{7{n4[3]}}, n4, op[3]} : 12'h0);
			end
			4: begin
				op = btop(b, s);
				b1 = 8'($urandom);
				d = u_mem.dmem[b1];
				b2 = (i == 4) ? 8'h80 : (i == 12) ? 8'h7F : 8'($urandom);
				if (b2 >= 8'hFD || b2 == 8'h00) b2 = 8'h10;
				tk = (d[b] == s);
				c = d[b];
				tgt = tk ? a + 12'h2 + {{4{b2[7]}}, b2} : a + 12'h3;
				nb = 3;
				cy = 5;
			end
			5: begin
				op = btop(b, s) | 8'h08;
				b1 = 8'($urandom);
				d = u_mem.dmem[b1];
				d[b] = s;
				nb = 2;
				cy = 4;
				tgt = a + 12'h2;
			end
			6: begin
				call = (i % 16 == 14);
				op = {tgt[11:8], call ? LN_CALL : LN_JP};
				b1 = tgt[7:0];
				nb = 2;
				cy = 4;
				if (call) u_mem.pmem[tgt] = OP_RET;
			end
			default: begin
				op = ctl[(i / 8) % 5];
				tgt = a + 12'h1;
			end
		endcase
		put(12'h0, {base[11:8], LN_JP}, base[7:0], OP_WAIT);
		put(base, {HN_LDI, LN_ALU}, v, btop(bp, 1'b1));
		put(base + 12'h3, rrp, 8'h01, {a[11:8], LN_JP});
		put(base + 12'h6, a[7:0], OP_WAIT, OP_WAIT);
		put(a, op, b1, b2);
		put(IRQ_VECTOR, {HN_LDI, LN_ALU}, zv, btop(3'h0, 1'b1));
		put(IRQ_VECTOR + 12'h3, 8'h81, 8'h01, OP_INTERRUPT_EXIT);
		watchdog_sel = (i >= 40);
		irq_pin = 1'b0;
		rst_n = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		wait_halt(1'b1);
		`CHK(fa[2], base)
		`CHK(ft[2] - ft[0], 8)
		`CHK(ft[4] - ft[2], 8)
		`CHK(ft[7] - ft[4], 10)
		`CHK(fa[9], a)
		if (op == OP_STOP || op == OP_WAIT) begin
			`CHK(nf, 10)
			`CHK({halt_stop, halt_wait}, (op == OP_STOP && i < 40) ? 2'b10 : 2'b01)
		end else begin
			`CHK(fa[9 + nb], tgt)
			`CHK(ft[9 + nb] - ft[9], 2 * cy)
		end
		if (call) `CHK(fa[12], a + 12'h2)
		if (i % 8 == 5) `CHK(u_mem.dmem[b1], d)
		`CHK(acc, v)
		`CHK({flag_z, flag_c}, {z, c})
		u_mem.dmem[8'h81][0] = !c;
		irq_pin = 1'b1;
		wait_halt(1'b0);
		irq_pin = 1'b0;
		wait_halt(1'b1);
		`CHK(acc, zv)
		`CHK({flag_z, flag_c}, {z, c})
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	initial begin
		#3200000;
		n_errors++;
		report_and_stop();
	end

	initial begin
		rst_n = 1'b0;
		watchdog_sel = 1'b0;
		irq_pin = 1'b0;
		n_errors = 0;
		check_count = 0;
		cyc = 0;
		nf = 0;
		ph = 1'b0;
		void'($urandom(62841));
		for (int i = 0; i < 80; i++) run_one(i);
		report_and_stop();
	end
endmodule
